// >>> gtv_pkg.sv
// Shared constants and types for the group ticket voucher flow control.
// Assumes one system clock at 100 MHz and an active-high asynchronous reset.
package gtv_pkg;
   localparam int GTV_GRP_W = 5;
   localparam int GTV_MEM_W = 5;
   localparam logic [4:0] GTV_GRP_NETMGMT = 5'h01;
   localparam logic [4:0] GTV_GRP_LANCOPY = 5'h02;
   localparam logic [4:0] GTV_GRP_SCCP = 5'h03;
   localparam logic [4:0] GTV_MEM_OVERFLOW = 5'h1f;
   localparam int GTV_XLATE_MAX = 25;
   localparam int GTV_CLK_MHZ = 100;
   localparam int GTV_AGE_LIMIT_MS = 2000;
   localparam longint GTV_AGE_LIMIT_CYC =
      longint'(GTV_AGE_LIMIT_MS) * 1000 * GTV_CLK_MHZ;
   localparam int GTV_REFRESH_CYC = 256;
   localparam logic [7:0] GTV_CNT_RST = 8'h00;

   typedef enum logic [1:0] {
      gtv_class_netmgmt_t_v,
      gtv_class_lancopy_t_v,
      gtv_class_sccp_t_v
   } gtv_class_t;

   typedef struct packed {
      logic valid;
      logic ticket;
      logic [4:0] field;
      logic [7:0] origin;
   } gtv_pkt_t;
endpackage

// >>> gtv_bus_if.sv
// Ring link between one bus station and the next on the inter module bus.
// Assumes both ends share clk_sys_i; the bench joins the ring.
interface gtv_bus_if;
   gtv_pkg::gtv_pkt_t pkt;
   modport station (output pkt);
   modport sink (input pkt);
endinterface

// >>> gtv_granter.sv
// Granter station: member numbering, grant counters and voucher handling.
// Assumes the upstream ring packet arrives on the same clock.
// Function
// - Classes map to groups one, two, three.
// - Member number is lowest free value 0..31.
// - At 25 or more translation cards, SCCP member is 31.
// - LAN-copy and SCCP numbers allocated separately.
// - Requester sends voucher carrying class group.
// - Voucher circulates until matching granter with capacity.
// - Grant: make ticket, member in field, decrement.
// - Counter of a bus selected in bus_sel_i at zero stops granting.
// - Counters reload periodically from free capacity.
// - Requester maps group and member to address.
// - Sequenced class 1 SCCP discarded by requester.
// - Full queue discards class 0 SCCP, LAN-copy.
// - Messages waiting over 2 seconds are discarded.
// - SCCP and LAN-copy discards bump sccp or lan_copy counters.
// - SCCP vouchers only for node-addressed messages.
module gtv_granter #(
   parameter int NUM_BUS = 2,
   parameter int CNT_W = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic enter_i,
   input wire logic [4:0] enter_group_i,
   input wire logic [31:0] taken_lan_i,
   input wire logic [31:0] taken_sccp_i,
   input wire logic [7:0] xlate_cards_i,
   input wire logic [NUM_BUS*CNT_W-1:0] capacity_i,
   input wire logic [NUM_BUS-1:0] bus_sel_i,
   output logic [4:0] group_o,
   output logic [4:0] member_o,
   output logic grant_o,
   gtv_bus_if.sink up,
   gtv_bus_if.station down
);
   import gtv_pkg::*;

   logic [4:0] group_q, group_d, member_q, member_d;
   logic [4:0] free_idx;
   logic [31:0] taken;
   logic [NUM_BUS*CNT_W-1:0] cnt_q, cnt_d;
   logic [7:0] ref_q, ref_d;
   gtv_pkt_t out_q, out_d;
   logic grant_q, grant_d, can_grant;

   always_comb begin
      taken = (enter_group_i == GTV_GRP_LANCOPY) ? taken_lan_i
                                                 : taken_sccp_i;
      free_idx = GTV_MEM_OVERFLOW;
      for (int i = 31; i >= 0; i--) begin
         if (!taken[i]) begin
            free_idx = 5'(i);
         end
      end
   end

   always_comb begin
      group_d = group_q;
      member_d = member_q;
      if (enter_i) begin
         group_d = enter_group_i;
         if (enter_group_i == GTV_GRP_SCCP &&
             xlate_cards_i >= 8'(GTV_XLATE_MAX)) begin
            member_d = GTV_MEM_OVERFLOW;
         end else begin
            member_d = free_idx;
         end
      end
   end

   always_comb begin
      can_grant = (group_q != 5'h00);
      for (int b = 0; b < NUM_BUS; b++) begin
         if (bus_sel_i[b] && cnt_q[b*CNT_W +: CNT_W] == '0) begin
            can_grant = 1'b0;
         end
      end
      cnt_d = cnt_q;
      ref_d = ref_q + 8'h01;
      // A card that cannot grant relays the packet untouched.
      out_d = up.pkt;
      grant_d = 1'b0;
      if (ref_q == 8'(GTV_REFRESH_CYC - 1)) begin
         cnt_d = capacity_i;
      end else if (up.pkt.valid && !up.pkt.ticket &&
                   up.pkt.field == group_q && can_grant) begin
         out_d.ticket = 1'b1;
         out_d.field = member_q;
         grant_d = 1'b1;
         for (int b = 0; b < NUM_BUS; b++) begin
            cnt_d[b*CNT_W +: CNT_W] = cnt_q[b*CNT_W +: CNT_W] - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         group_q <= 5'h00;
         member_q <= 5'h00;
         cnt_q <= '0;
         ref_q <= GTV_CNT_RST;
         out_q <= '0;
         grant_q <= 1'b0;
      end else begin
         group_q <= group_d;
         member_q <= member_d;
         cnt_q <= cnt_d;
         ref_q <= ref_d;
         out_q <= out_d;
         grant_q <= grant_d;
      end
   end

   assign down.pkt = out_q;
   assign group_o = group_q;
   assign member_o = member_q;
   assign grant_o = grant_q;
endmodule

// >>> gtv_requester.sv
// Requesting link card: voucher issue, ticket return, discard accounting.
// Assumes the ring returns its own voucher or ticket on the same clock.
module gtv_requester #(
   parameter logic [7:0] STATION_ID = 8'h01,
   parameter longint AGE_LIMIT = gtv_pkg::GTV_AGE_LIMIT_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic msg_valid_i,
   input wire gtv_pkg::gtv_class_t msg_class_i,
   input wire logic msg_seq_class1_i,
   input wire logic msg_to_node_i,
   input wire logic queue_full_i,
   output logic msg_ready_o,
   output logic send_o,
   output logic [9:0] send_addr_o,
   output logic [15:0] sccp_discard_count_o,
   output logic [15:0] lan_copy_discard_count_o,
   gtv_bus_if.sink up,
   gtv_bus_if.station down
);
   import gtv_pkg::*;

   typedef enum logic [1:0] {gtv_idle, gtv_issue, gtv_wait} gtv_st_t;
   gtv_st_t st_q, st_d;
   logic [4:0] grp_q, grp_d;
   gtv_class_t cls_q, cls_d;
   logic [31:0] age_q, age_d;
   logic [15:0] sd_q, sd_d, ld_q, ld_d;
   logic send_q, send_d;
   logic [9:0] addr_q, addr_d;
   gtv_pkt_t out_q, out_d;
   logic [4:0] grp_of;
   logic mine;

   always_comb begin
      case (msg_class_i)
         gtv_class_netmgmt_t_v: grp_of = GTV_GRP_NETMGMT;
         gtv_class_lancopy_t_v: grp_of = GTV_GRP_LANCOPY;
         default: grp_of = GTV_GRP_SCCP;
      endcase
   end

   assign mine = up.pkt.valid && up.pkt.origin == STATION_ID;
   assign msg_ready_o = (st_q == gtv_idle);

   always_comb begin
      st_d = st_q;
      grp_d = grp_q;
      cls_d = cls_q;
      age_d = age_q;
      sd_d = sd_q;
      ld_d = ld_q;
      send_d = 1'b0;
      addr_d = addr_q;
      // Foreign packets are relayed; our own are removed from the ring.
      out_d = mine ? '0 : up.pkt;
      case (st_q)
         gtv_idle: begin
            if (msg_valid_i) begin
               if (msg_class_i == gtv_class_sccp_t_v && !msg_to_node_i) begin
                  send_d = 1'b0;
               end else if (msg_class_i == gtv_class_sccp_t_v &&
                            msg_seq_class1_i) begin
                  sd_d = sd_q + 16'h0001;
               end else if (queue_full_i &&
                            msg_class_i != gtv_class_netmgmt_t_v) begin
                  if (msg_class_i == gtv_class_sccp_t_v) begin
                     sd_d = sd_q + 16'h0001;
                  end else begin
                     ld_d = ld_q + 16'h0001;
                  end
               end else begin
                  grp_d = grp_of;
                  cls_d = msg_class_i;
                  age_d = '0;
                  st_d = gtv_issue;
               end
            end
         end
         gtv_issue: begin
            if (!up.pkt.valid || mine) begin
               out_d = '{valid: 1'b1, ticket: 1'b0, field: grp_q,
                         origin: STATION_ID};
               st_d = gtv_wait;
            end
            age_d = age_q + 32'h1;
         end
         default: begin
            age_d = age_q + 32'h1;
            if (mine && up.pkt.ticket) begin
               addr_d = {grp_q, up.pkt.field};
               send_d = 1'b1;
               st_d = gtv_idle;
            end else if (age_q >= 32'(AGE_LIMIT)) begin
               // A timed-out management message feeds neither counter.
               if (cls_q == gtv_class_lancopy_t_v) begin
                  ld_d = ld_q + 16'h0001;
               end else if (cls_q == gtv_class_sccp_t_v) begin
                  sd_d = sd_q + 16'h0001;
               end
               st_d = gtv_idle;
            end else if (mine) begin
               // An unanswered voucher goes round again.
               out_d = up.pkt;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= gtv_idle;
         grp_q <= 5'h00;
         cls_q <= gtv_class_netmgmt_t_v;
         age_q <= '0;
         sd_q <= '0;
         ld_q <= '0;
         send_q <= 1'b0;
         addr_q <= '0;
         out_q <= '0;
      end else begin
         st_q <= st_d;
         grp_q <= grp_d;
         cls_q <= cls_d;
         age_q <= age_d;
         sd_q <= sd_d;
         ld_q <= ld_d;
         send_q <= send_d;
         addr_q <= addr_d;
         out_q <= out_d;
      end
   end

   assign down.pkt = out_q;
   assign send_o = send_q;
   assign send_addr_o = addr_q;
   assign sccp_discard_count_o = sd_q;
   assign lan_copy_discard_count_o = ld_q;
endmodule

// >>> gtv_assertions.sv
// Checker on the two ring links of a one requester, one granter ring.
// Assumes the granter serves group GRP and the requester is station STN.
module gtv_assertions #(
   parameter logic [4:0] GRP = 5'h03,
   parameter logic [7:0] STN = 8'h01
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire gtv_pkg::gtv_pkt_t req_pkt,
   input wire gtv_pkg::gtv_pkt_t gnt_pkt
);
   timeunit 1ns;
   timeprecision 1ps;
   import gtv_pkg::*;
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   sequence s_vch;
      req_pkt.valid && !req_pkt.ticket;
   endsequence
   sequence s_tkt;
      gnt_pkt.valid && gnt_pkt.ticket;
   endsequence
   property p_grp;
      s_vch |-> req_pkt.field inside {[GTV_GRP_NETMGMT:GTV_GRP_SCCP]};
   endproperty
   a_grp: assert property (p_grp) else $error("bad group");
   property p_org;
      req_pkt.valid |-> req_pkt.origin == STN;
   endproperty
   a_org: assert property (p_org) else $error("bad origin");
   property p_fwd;
      s_vch ##0 req_pkt.field != GRP |=> gnt_pkt == $past(req_pkt);
   endproperty
   a_fwd: assert property (p_fwd) else $error("voucher altered");
   property p_mine;
      s_vch ##0 req_pkt.field == GRP |=>
         gnt_pkt.ticket || gnt_pkt == $past(req_pkt);
   endproperty
   a_mine: assert property (p_mine) else $error("bad grant");
   property p_tkt;
      s_tkt |-> $past(req_pkt.valid) && $past(req_pkt.field) == GRP &&
         !$past(req_pkt.ticket) && gnt_pkt.origin == $past(req_pkt.origin);
   endproperty
   a_tkt: assert property (p_tkt) else $error("bad ticket");
   property p_idle;
      !req_pkt.valid |=> !gnt_pkt.valid;
   endproperty
   a_idle: assert property (p_idle) else $error("packet made up");
   property p_carry;
      req_pkt.valid |=> gnt_pkt.valid;
   endproperty
   a_carry: assert property (p_carry) else $error("packet lost");
   property p_absorb;
      s_tkt |=> !(req_pkt.valid && req_pkt.ticket);
   endproperty
   a_absorb: assert property (p_absorb) else $error("ticket kept");
endmodule

// >>> test_gtv.sv
// Bench joining one requester and one granter in a two-station ring.
// Assumes the package, ring interface and checker are compiled first.
module test_group_ticket_voucher_flow_control;
   timeunit 1ns;
   timeprecision 1ps;
   import gtv_pkg::*;
   logic clk_sys_i = 0, rst_i = 1, enter_i = 0, msg_valid_i = 0;
   logic msg_seq_class1_i = 0, msg_to_node_i = 0, queue_full_i = 0;
   logic [4:0] enter_group_i = 5'h03, group_o, member_o;
   logic [31:0] taken_lan_i = '0, taken_sccp_i = '0;
   logic [7:0] xlate_cards_i = 8'h00;
   logic [15:0] capacity_i = 16'h0000, sccp_cnt, lan_cnt;
   logic [1:0] bus_sel_i = 2'h3;
   logic [9:0] send_addr_o;
   logic grant_o, msg_ready_o, send_o;
   gtv_class_t msg_class_i = gtv_class_sccp_t_v;
   int miscompares = 0, samples_checked = 0, grants = 0;
   logic [4:0] last_vch = 5'h00;
   gtv_bus_if b_rg ();
   gtv_bus_if b_gr ();
   gtv_requester #(.AGE_LIMIT(200)) u_gtv_requester (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .msg_valid_i(msg_valid_i), .msg_class_i(msg_class_i),
      .msg_seq_class1_i(msg_seq_class1_i), .msg_to_node_i(msg_to_node_i),
      .queue_full_i(queue_full_i), .msg_ready_o(msg_ready_o),
      .send_o(send_o), .send_addr_o(send_addr_o),
      .sccp_discard_count_o(sccp_cnt), .lan_copy_discard_count_o(lan_cnt),
      .up(b_gr), .down(b_rg));
   gtv_granter u_gtv_granter (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .enter_i(enter_i), .enter_group_i(enter_group_i),
      .taken_lan_i(taken_lan_i), .taken_sccp_i(taken_sccp_i),
      .xlate_cards_i(xlate_cards_i), .capacity_i(capacity_i),
      .bus_sel_i(bus_sel_i), .group_o(group_o), .member_o(member_o),
      .grant_o(grant_o), .up(b_rg), .down(b_gr));
   gtv_assertions u_gtv_assertions (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .req_pkt(b_rg.pkt), .gnt_pkt(b_gr.pkt));
   always #5 clk_sys_i = ~clk_sys_i;
   // Design outputs are sampled on the falling edge, where they are settled.
   always @(negedge clk_sys_i) begin
      if (grant_o === 1'b1) grants++;
      if (b_rg.pkt.valid === 1'b1 && b_rg.pkt.ticket === 1'b0) begin
         last_vch = b_rg.pkt.field;
      end
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic enter(logic [4:0] g, logic [31:0] tl, ts, logic [7:0] x,
         logic [4:0] em);
      cyc(1);
      enter_i = 1;
      enter_group_i = g;
      taken_lan_i = tl;
      taken_sccp_i = ts;
      xlate_cards_i = x;
      cyc(1);
      enter_i = 0;
      cyc(1);
      chk("member", {11'h0, em}, {11'h0, member_o});
      chk("group", {11'h0, g}, {11'h0, group_o});
   endtask
   task automatic send(gtv_class_t c, logic sq, nd, fl);
      int n;
      cyc(1);
      msg_valid_i = 1;
      msg_class_i = c;
      msg_seq_class1_i = sq;
      msg_to_node_i = nd;
      queue_full_i = fl;
      for (n = 0; msg_ready_o !== 1'b1 && n < 500; n++) cyc(1);
      cyc(1);
      msg_valid_i = 0;
   endtask
   task automatic t_reset();
      chk("sccp_cnt", 16'h0, sccp_cnt);
      chk("lan_cnt", 16'h0, lan_cnt);
      chk("send", 16'h0, {15'h0, send_o});
   endtask
   task automatic t_member();
      enter(GTV_GRP_SCCP, 32'h0, 32'h7, 8'h00, 5'h03);
      enter(GTV_GRP_LANCOPY, 32'h1, 32'h7, 8'h00, 5'h01);
      enter(GTV_GRP_SCCP, 32'h0, 32'h7, 8'h19, GTV_MEM_OVERFLOW);
      enter(GTV_GRP_SCCP, 32'h0, 32'h1, 8'h00, 5'h01);
   endtask
   task automatic t_dry();
      send(gtv_class_sccp_t_v, 0, 1, 0);
      cyc(300);
      chk("grants", 16'h0, grants[15:0]);
      chk("sccp_cnt", 16'h1, sccp_cnt);
   endtask
   task automatic t_grant();
      int n;
      capacity_i = 16'h0201;
      cyc(260);
      send(gtv_class_sccp_t_v, 0, 1, 0);
      for (n = 0; send_o !== 1'b1 && n < 100; n++) cyc(1);
      capacity_i = 16'h0000;
      chk("vch_grp", {11'h0, GTV_GRP_SCCP}, {11'h0, last_vch});
      chk("addr", {6'h0, GTV_GRP_SCCP, 5'h01}, {6'h0, send_addr_o});
      chk("grants", 16'h1, grants[15:0]);
      send(gtv_class_sccp_t_v, 0, 1, 0);
      cyc(300);
      chk("grants", 16'h1, grants[15:0]);
      chk("sccp_cnt", 16'h2, sccp_cnt);
   endtask
   task automatic t_discard();
      send(gtv_class_sccp_t_v, 1, 1, 0);
      send(gtv_class_sccp_t_v, 0, 1, 1);
      send(gtv_class_sccp_t_v, 0, 0, 0);
      send(gtv_class_lancopy_t_v, 0, 1, 1);
      send(gtv_class_lancopy_t_v, 0, 1, 0);
      send(gtv_class_netmgmt_t_v, 0, 1, 1);
      cyc(300);
      chk("sccp_cnt", 16'h4, sccp_cnt);
      chk("lan_cnt", 16'h2, lan_cnt);
      chk("vch_grp", {11'h0, GTV_GRP_NETMGMT}, {11'h0, last_vch});
      chk("grants", 16'h1, grants[15:0]);
   endtask
   initial begin
      #50us;
      miscompares++;
      end_of_test();
   end
   initial begin
      cyc(8);
      rst_i = 0;
      t_reset();
      t_member();
      t_dry();
      t_grant();
      t_discard();
      end_of_test();
   end
endmodule
